// ---- core/seq_core_defs.svh ----
// Constants of the 4-bit sequencer core: offsets, field positions, reset values
`ifndef SEQ_CORE_DEFS_SVH
`define SEQ_CORE_DEFS_SVH

`define PC_W 10
`define PC_RESET 10'h000
`define CALL_PUSH_INC 10'h001
`define EXIT_INC 10'h002
`define SP_RESET 2'h0
`define SP_TOP 2'h3
`define SP_BOTTOM 2'h0
`define ACC_W 4
`define ACC_FULL 4'hf
`define RAM_WORDS 32
`define RAM_W 5
`define RAM_AW 5
`define STACK_TOP_ROW 4'hf
`define PTR_HI_ADDR 5'h10
`define PTR_LO_ADDR 5'h00
`define CTRL_W 10
`define CTRL_RESET 10'h000
`define CTRL_SERIAL_BIT 0
`define CTRL_PAGE_LO 4
`define CTRL_PAGE_HI 5
`define REG_ADDR_W 4
`define REG_CTRL 4'h0
`define REG_PC 4'h4
`define REG_CORE 4'h8

`endif

// ---- core/seq_core_pkg.sv ----
// Types shared by the sequencer core and its ALU
`include "seq_core_defs.svh"
package seq_core_pkg;

    typedef enum logic [4:0] {
        OP_ADVANCE = 5'h00,
        OP_JUMP_DIRECT = 5'h01,
        OP_JUMP_ON_CARRY = 5'h02,
        OP_JUMP_ON_MATCH = 5'h03,
        OP_JUMP_INDIRECT = 5'h04,
        OP_CALL = 5'h05,
        OP_EXIT = 5'h06,
        OP_TABLE_READ = 5'h07,
        OP_INC_ACC = 5'h08,
        OP_ROTATE_LEFT = 5'h09,
        OP_SET_CARRY_IF_FULL = 5'h0a,
        OP_PIN_TEST = 5'h0b,
        OP_LOAD_ACC = 5'h0c,
        OP_STORE_ACC = 5'h0d,
        OP_LOAD_IMM = 5'h0e,
        OP_ADD_RAM = 5'h0f,
        OP_AND_RAM = 5'h10,
        OP_OR_RAM = 5'h11,
        OP_XOR_RAM = 5'h12
    } op_t;

    typedef enum logic [2:0] {
        ALU_PASS = 3'h0,
        ALU_ADD = 3'h1,
        ALU_INC = 3'h2,
        ALU_RL = 3'h3,
        ALU_AND = 3'h4,
        ALU_OR = 3'h5,
        ALU_XOR = 3'h6
    } alu_func_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_FETCH = 4'h2,
        S_EXEC = 4'h4,
        S_PUSH_LO = 4'h8
    } state_t;

    typedef struct packed {
        op_t op;
        logic [1:0] len;
        logic [`PC_W-1:0] imm;
        logic [`RAM_AW-1:0] ram_addr;
    } exec_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`REG_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

endpackage

// ---- core/seq_data_ram.sv ----
// Data memory, 32 words of 5 bits, registered read, contents never reset
`timescale 1ns/1ps
`include "seq_core_defs.svh"
module seq_data_ram #(
    parameter int DEPTH = `RAM_WORDS,
    parameter int WIDTH = `RAM_W
) (
    // Clock
    input wire logic sys_clk,
    // Write side
    input wire logic we,
    input wire logic [`RAM_AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read side
    input wire logic [`RAM_AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    if (DEPTH != `RAM_WORDS || WIDTH < `RAM_W) begin : g_bad_size
        $error("data ram needs 32 words of at least 5 bits");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_ff;

    // No reset here: contents survive reset and all-clear
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        rdata_ff <= mem[raddr];
    end

    assign rdata = rdata_ff;

endmodule

// ---- core/seq_alu4.sv ----
// Four-bit ALU of the sequencer core
`timescale 1ns/1ps
`include "seq_core_defs.svh"
module seq_alu4 (
    // Operation
    input wire seq_core_pkg::alu_func_t func,
    input wire logic [`ACC_W-1:0] a,
    input wire logic [`ACC_W-1:0] b,
    input wire logic rl_fill,
    // Result
    output logic [`ACC_W-1:0] y,
    output logic cout
);

    logic [`ACC_W:0] sum;

    always_comb begin
        sum = {1'b0, a} + {1'b0, b};
        y = b;
        cout = 1'b0;
        unique case (func)
            seq_core_pkg::ALU_PASS: begin
                y = b;
            end
            seq_core_pkg::ALU_ADD: begin
                y = sum[`ACC_W-1:0];
                cout = sum[`ACC_W];
            end
            seq_core_pkg::ALU_INC: begin
                sum = {1'b0, a} + 5'h01;
                y = sum[`ACC_W-1:0];
                cout = sum[`ACC_W];
            end
            seq_core_pkg::ALU_RL: begin
                y = {a[`ACC_W-2:0], rl_fill};
                cout = a[`ACC_W-1];
            end
            seq_core_pkg::ALU_AND: begin
                y = a & b;
            end
            seq_core_pkg::ALU_OR: begin
                y = a | b;
            end
            seq_core_pkg::ALU_XOR: begin
                y = a ^ b;
            end
            default: begin
                y = b;
            end
        endcase
    end

endmodule

// ---- core/seq_core.sv ----
// Program sequencer, stack, accumulator, flags and register port of the 4-bit core
`timescale 1ns/1ps
`include "seq_core_defs.svh"
module seq_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Pins
    input wire logic all_clear_pin,
    input wire logic serial_in_pin,
    input wire logic pin_match_pin,
    // Decoded instruction
    input wire logic exec_valid,
    input wire seq_core_pkg::exec_req_t exec_req,
    output logic exec_ready,
    // Program memory side
    output logic [`PC_W-1:0] program_counter,
    output logic [`PC_W-1:0] table_addr,
    output logic table_valid,
    // Register port
    input wire seq_core_pkg::reg_req_t reg_req,
    output logic [31:0] reg_rdata
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: bit 0 all-clear, bit 1 serial input, bit 2 pin match

    logic [2:0] pin_raw;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] sync3_ff;
    logic [2:0] pin_ff;
    logic clear_all;

    assign pin_raw = {pin_match_pin, serial_in_pin, all_clear_pin};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            sync3_ff <= 3'h0;
            pin_ff <= 3'h0;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pin_ff <= (~(sync2_ff ^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & pin_ff);
        end
    end

    assign clear_all = reset | pin_ff[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Stack addressing

    // Row of a stack level; level zero is the top row
    function automatic logic [3:0] stack_row(input logic [1:0] level);
        stack_row = `STACK_TOP_ROW - {2'h0, level};
    endfunction

    // First word (hi) or second word (lo) that an operation reads
    function automatic logic [`RAM_AW-1:0] read_addr(input seq_core_pkg::op_t op,
                                                     input logic [`RAM_AW-1:0] ra,
                                                     input logic [1:0] sp,
                                                     input logic hi);
        if (op == seq_core_pkg::OP_EXIT) begin
            read_addr = {hi, stack_row(sp - 2'h1)};
        end else if (op == seq_core_pkg::OP_TABLE_READ) begin
            read_addr = hi ? `PTR_HI_ADDR : `PTR_LO_ADDR;
        end else begin
            read_addr = ra;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    seq_core_pkg::state_t state_ff;
    seq_core_pkg::state_t nxt_state;
    seq_core_pkg::exec_req_t req_ff;
    logic [`PC_W-1:0] pc_ff;
    logic [`PC_W-1:0] nxt_pc;
    logic [1:0] sp_ff;
    logic [1:0] nxt_sp;
    logic fault;
    logic [`ACC_W-1:0] acc_ff;
    logic carry_ff;
    logic status_ff;
    logic [`CTRL_W-1:0] ctrl_ff;
    logic [`RAM_W-1:0] word_a_ff;
    logic [`RAM_W-1:0] push_lo_ff;
    logic [`RAM_AW-1:0] push_addr_ff;
    logic [`PC_W-1:0] table_addr_ff;
    logic table_valid_ff;
    logic [31:0] reg_rdata_ff;
    logic accept;
    logic in_exec;
    logic [`PC_W-1:0] seq_pc;
    logic [`PC_W-1:0] ret_pc;
    logic [`PC_W-1:0] stacked_pc;

    logic ram_we;
    logic [`RAM_AW-1:0] ram_waddr;
    logic [`RAM_W-1:0] ram_wdata;
    logic [`RAM_AW-1:0] ram_raddr;
    logic [`RAM_W-1:0] ram_rdata;

    seq_core_pkg::alu_func_t alu_func;
    logic [`ACC_W-1:0] alu_b;
    logic [`ACC_W-1:0] alu_y;
    logic alu_cout;
    logic rl_fill;
    logic acc_load;

    assign exec_ready = (state_ff == seq_core_pkg::S_IDLE) && !clear_all;
    assign accept = exec_valid && exec_ready;
    assign in_exec = (state_ff == seq_core_pkg::S_EXEC);
    assign seq_pc = pc_ff + {8'h00, req_ff.len};
    assign ret_pc = pc_ff + `CALL_PUSH_INC;
    assign stacked_pc = {word_a_ff, ram_rdata};

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            seq_core_pkg::S_IDLE: begin
                if (accept) nxt_state = seq_core_pkg::S_FETCH;
            end
            seq_core_pkg::S_FETCH: begin
                nxt_state = seq_core_pkg::S_EXEC;
            end
            seq_core_pkg::S_EXEC: begin
                if (req_ff.op == seq_core_pkg::OP_CALL && !fault) begin
                    nxt_state = seq_core_pkg::S_PUSH_LO;
                end else begin
                    nxt_state = seq_core_pkg::S_IDLE;
                end
            end
            seq_core_pkg::S_PUSH_LO: begin
                nxt_state = seq_core_pkg::S_IDLE;
            end
            default: begin
                nxt_state = seq_core_pkg::S_IDLE;
            end
        endcase
    end

    always_comb begin
        nxt_pc = pc_ff;
        nxt_sp = sp_ff;
        fault = 1'b0;
        if (in_exec) begin
            unique case (req_ff.op)
                seq_core_pkg::OP_JUMP_DIRECT: nxt_pc = req_ff.imm;
                seq_core_pkg::OP_JUMP_ON_CARRY: nxt_pc = carry_ff ? req_ff.imm : seq_pc;
                seq_core_pkg::OP_JUMP_ON_MATCH: nxt_pc = status_ff ? req_ff.imm : seq_pc;
                seq_core_pkg::OP_JUMP_INDIRECT: nxt_pc = {req_ff.imm[`PC_W-1:4], ram_rdata[3:0]};
                seq_core_pkg::OP_CALL: begin
                    if (sp_ff == `SP_TOP) begin
                        fault = 1'b1;
                        nxt_pc = `PC_RESET;
                    end else begin
                        nxt_pc = req_ff.imm;
                        nxt_sp = sp_ff + 2'h1;
                    end
                end
                seq_core_pkg::OP_EXIT: begin
                    if (sp_ff == `SP_BOTTOM) begin
                        fault = 1'b1;
                        nxt_pc = `PC_RESET;
                    end else begin
                        nxt_pc = stacked_pc + `EXIT_INC;
                        nxt_sp = sp_ff - 2'h1;
                    end
                end
                default: nxt_pc = seq_pc;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clear_all) begin
            state_ff <= seq_core_pkg::S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clear_all) begin
            pc_ff <= `PC_RESET;
            sp_ff <= `SP_RESET;
        end else begin
            pc_ff <= nxt_pc;
            sp_ff <= nxt_sp;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (accept) begin
            req_ff <= exec_req;
        end
        if (state_ff == seq_core_pkg::S_FETCH) begin
            word_a_ff <= ram_rdata;
        end
        if (in_exec) begin
            push_lo_ff <= ret_pc[4:0];
            push_addr_ff <= {1'b0, stack_row(sp_ff)};
        end
    end

    assign program_counter = pc_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory and stack traffic

    always_comb begin
        if (state_ff == seq_core_pkg::S_IDLE) begin
            ram_raddr = read_addr(exec_req.op, exec_req.ram_addr, sp_ff, 1'b1);
        end else begin
            ram_raddr = read_addr(req_ff.op, req_ff.ram_addr, sp_ff, 1'b0);
        end
    end

    always_comb begin
        ram_we = 1'b0;
        ram_waddr = req_ff.ram_addr;
        ram_wdata = {1'b0, acc_ff};
        if (in_exec && req_ff.op == seq_core_pkg::OP_STORE_ACC) begin
            ram_we = 1'b1;
        end else if (in_exec && req_ff.op == seq_core_pkg::OP_CALL && !fault) begin
            ram_we = 1'b1;
            ram_waddr = {1'b1, stack_row(sp_ff)};
            ram_wdata = ret_pc[`PC_W-1:5];
        end else if (state_ff == seq_core_pkg::S_PUSH_LO) begin
            ram_we = 1'b1;
            ram_waddr = push_addr_ff;
            ram_wdata = push_lo_ff;
        end
    end

    seq_data_ram #(
        .DEPTH(`RAM_WORDS),
        .WIDTH(`RAM_W)
    ) u_ram (
        .sys_clk(sys_clk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );

    // Pointer pair lives in data memory, so it keeps whatever it held
    always_ff @(posedge sys_clk) begin
        if (clear_all) begin
            table_valid_ff <= 1'b0;
            table_addr_ff <= `PC_RESET;
        end else begin
            table_valid_ff <= in_exec && req_ff.op == seq_core_pkg::OP_TABLE_READ;
            if (in_exec && req_ff.op == seq_core_pkg::OP_TABLE_READ) begin
                table_addr_ff <= {ctrl_ff[`CTRL_PAGE_HI:`CTRL_PAGE_LO], word_a_ff[3:0], ram_rdata[3:0]};
            end
        end
    end

    assign table_addr = table_addr_ff;
    assign table_valid = table_valid_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulator, ALU and flags

    always_comb begin
        alu_func = seq_core_pkg::ALU_PASS;
        acc_load = in_exec;
        unique case (req_ff.op)
            seq_core_pkg::OP_INC_ACC: alu_func = seq_core_pkg::ALU_INC;
            seq_core_pkg::OP_ROTATE_LEFT: alu_func = seq_core_pkg::ALU_RL;
            seq_core_pkg::OP_ADD_RAM: alu_func = seq_core_pkg::ALU_ADD;
            seq_core_pkg::OP_AND_RAM: alu_func = seq_core_pkg::ALU_AND;
            seq_core_pkg::OP_OR_RAM: alu_func = seq_core_pkg::ALU_OR;
            seq_core_pkg::OP_XOR_RAM: alu_func = seq_core_pkg::ALU_XOR;
            seq_core_pkg::OP_LOAD_ACC: alu_func = seq_core_pkg::ALU_PASS;
            seq_core_pkg::OP_LOAD_IMM: alu_func = seq_core_pkg::ALU_PASS;
            default: acc_load = 1'b0;
        endcase
    end

    assign alu_b = (req_ff.op == seq_core_pkg::OP_LOAD_IMM) ? req_ff.imm[`ACC_W-1:0] : ram_rdata[`ACC_W-1:0];
    assign rl_fill = ctrl_ff[`CTRL_SERIAL_BIT] ? pin_ff[1] : acc_ff[`ACC_W-1];

    seq_alu4 u_alu (
        .func(alu_func),
        .a(acc_ff),
        .b(alu_b),
        .rl_fill(rl_fill),
        .y(alu_y),
        .cout(alu_cout)
    );

    // Accumulator and flags are data: no reset
    always_ff @(posedge sys_clk) begin
        if (acc_load) begin
            acc_ff <= alu_y;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (in_exec) begin
            unique case (req_ff.op)
                seq_core_pkg::OP_INC_ACC, seq_core_pkg::OP_ROTATE_LEFT, seq_core_pkg::OP_ADD_RAM: begin
                    carry_ff <= alu_cout;
                end
                seq_core_pkg::OP_SET_CARRY_IF_FULL: begin
                    if (acc_ff == `ACC_FULL) carry_ff <= 1'b1;
                end
                default: begin
                    carry_ff <= carry_ff;
                end
            endcase
            if (req_ff.op == seq_core_pkg::OP_PIN_TEST) begin
                status_ff <= pin_ff[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port

    always_ff @(posedge sys_clk) begin
        if (clear_all) begin
            ctrl_ff <= `CTRL_RESET;
        end else if (reg_req.wr && reg_req.addr == `REG_CTRL) begin
            ctrl_ff <= reg_req.wdata[`CTRL_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata_ff <= 32'h0;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `REG_CTRL: reg_rdata_ff <= {22'h0, ctrl_ff};
                `REG_PC: reg_rdata_ff <= {22'h0, pc_ff};
                `REG_CORE: reg_rdata_ff <= {24'h0, sp_ff, status_ff, carry_ff, acc_ff};
                default: reg_rdata_ff <= 32'h0;
            endcase
        end else begin
            reg_rdata_ff <= 32'h0;
        end
    end

    assign reg_rdata = reg_rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (clear_all);

    property p_advance;
        accept && exec_req.op == seq_core_pkg::OP_ADVANCE
            |-> ##3 pc_ff == $past(pc_ff, 3) + {8'h00, $past(exec_req.len, 3)};
    endproperty
    a_advance: assert property (p_advance) else $error("pc did not advance by length");

    property p_jump_direct;
        accept && exec_req.op == seq_core_pkg::OP_JUMP_DIRECT |-> ##3 pc_ff == $past(exec_req.imm, 3);
    endproperty
    a_jump_direct: assert property (p_jump_direct) else $error("direct jump missed target");

    property p_call_push;
        accept && exec_req.op == seq_core_pkg::OP_CALL && sp_ff != `SP_TOP
            |-> ##2 (ram_we && ram_wdata == ret_pc[`PC_W-1:5]) ##1 (ram_we && pc_ff == req_ff.imm);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call did not push and jump");

    property p_exit;
        in_exec && req_ff.op == seq_core_pkg::OP_EXIT && sp_ff != `SP_BOTTOM
            |=> pc_ff == $past(stacked_pc) + `EXIT_INC && sp_ff == $past(sp_ff) - 2'h1;
    endproperty
    a_exit: assert property (p_exit) else $error("exit did not load stack plus two");

    property p_clear;
        @(posedge sys_clk) disable iff (1'b0) clear_all |=> pc_ff == `PC_RESET && sp_ff == `SP_RESET;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left pc or index");

    property p_call_index;
        accept && exec_req.op == seq_core_pkg::OP_CALL && sp_ff != `SP_TOP |-> ##3 sp_ff == $past(sp_ff, 3) + 2'h1;
    endproperty
    a_call_index: assert property (p_call_index) else $error("call did not bump index");

    property p_overflow;
        accept && exec_req.op == seq_core_pkg::OP_CALL && sp_ff == `SP_TOP |-> ##3 pc_ff == `PC_RESET && exec_ready;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow did not reset pc");

    property p_table;
        table_valid |-> table_addr[`PC_W-1:8] == ctrl_ff[`CTRL_PAGE_HI:`CTRL_PAGE_LO];
    endproperty
    a_table: assert property (p_table) else $error("table page bits wrong");

    property p_full_carry;
        accept && exec_req.op == seq_core_pkg::OP_SET_CARRY_IF_FULL && acc_ff == `ACC_FULL |-> ##3 carry_ff;
    endproperty
    a_full_carry: assert property (p_full_carry) else $error("full accumulator left carry clear");

    property p_no_carry_jump;
        accept && exec_req.op == seq_core_pkg::OP_JUMP_ON_CARRY && !carry_ff
            |-> ##3 pc_ff == $past(pc_ff, 3) + {8'h00, $past(exec_req.len, 3)};
    endproperty
    a_no_carry_jump: assert property (p_no_carry_jump) else $error("carry jump taken without carry");

    c_call_exit: cover property (in_exec && req_ff.op == seq_core_pkg::OP_EXIT && sp_ff == 2'h2);
    c_overflow: cover property (in_exec && req_ff.op == seq_core_pkg::OP_CALL && fault);
    c_table: cover property (table_valid);

endmodule

// ---- dv/prog_rom_model.sv ----
// Program memory model: ten-bit words read by the counter and by table lookups
`timescale 1ns/1ps
module prog_rom_model (
    // Clock
    input wire logic sys_clk,
    // Address side
    input wire logic [9:0] program_counter,
    input wire logic [9:0] table_addr,
    input wire logic table_valid,
    // Data side
    output logic [9:0] fetch_word,
    output logic [9:0] table_word
);
    logic [9:0] mem [1024];
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 10'(i * 37 + 5);
        end
    end
    // Table data only stands in the cycle after a lookup
    always_ff @(posedge sys_clk) begin
        fetch_word <= mem[program_counter];
        table_word <= table_valid ? mem[table_addr] : ~table_word;
    end
endmodule

// ---- dv/seq_core_tb.sv ----
// Self-checking bench of the sequencer core against a behavioural model
`timescale 1ns/1ps
module seq_core_tb;
    logic sys_clk = 0, reset = 1, all_clear_pin = 0, serial_in_pin = 0, pin_match_pin = 0;
    logic exec_valid = 0, exec_ready, table_valid;
    seq_core_pkg::exec_req_t exec_req = '0;
    seq_core_pkg::reg_req_t reg_req = '0;
    logic [9:0] program_counter, table_addr, fetch_word, table_word;
    logic [31:0] reg_rdata;
    int failures = 0, tests_run = 0;
    int pc = 0, sp = 0, acc, cy, st, ctl = 0, msk = 'hc0, tab;
    int stk[$];
    int ram[32];
    always #12.5 sys_clk = ~sys_clk;
    seq_core dut_u (.sys_clk(sys_clk), .reset(reset), .all_clear_pin(all_clear_pin), .serial_in_pin(serial_in_pin),
        .pin_match_pin(pin_match_pin), .exec_valid(exec_valid), .exec_req(exec_req), .exec_ready(exec_ready),
        .program_counter(program_counter), .table_addr(table_addr), .table_valid(table_valid),
        .reg_req(reg_req), .reg_rdata(reg_rdata));
    prog_rom_model rom_u (.sys_clk(sys_clk), .program_counter(program_counter), .table_addr(table_addr),
        .table_valid(table_valid), .fetch_word(fetch_word), .table_word(table_word));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        tests_run++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '0;
        #1;
    endtask
    task automatic chk_all();
        bus(0, 4'h4, 0);
        chk(reg_rdata, pc, 32'h3ff);
        chk(program_counter, pc, 32'h3ff);
        chk(fetch_word, rom_u.mem[pc], 32'h3ff);
        bus(0, 4'h8, 0);
        chk(reg_rdata, sp << 6 | st << 5 | cy << 4 | acc, msk);
    endtask
    task automatic wait_ready();
        int n = 0;
        @(negedge sys_clk);
        while (exec_ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        chk(32'(n < 50), 1, 1);
    endtask
    task automatic run(input seq_core_pkg::op_t o, input int imm, input int ra = 0, input int len = 1);
        int old = pc;
        wait_ready();
        @(posedge sys_clk);
        exec_valid <= 1;
        exec_req <= '{op: o, len: 2'(len), imm: 10'(imm), ram_addr: 5'(ra)};
        @(posedge sys_clk);
        exec_valid <= 0;
        wait_ready();
        pc = (pc + len) % 1024;
        case (o)
            seq_core_pkg::OP_JUMP_DIRECT: pc = imm;
            seq_core_pkg::OP_JUMP_ON_CARRY: if (cy) pc = imm;
            seq_core_pkg::OP_JUMP_ON_MATCH: if (st) pc = imm;
            seq_core_pkg::OP_CALL: if (sp == 3) pc = 0;
            else begin
                stk.push_back((old + 1) % 1024);
                sp++;
                pc = imm;
            end
            seq_core_pkg::OP_EXIT: if (sp == 0) pc = 0;
            else begin
                sp--;
                pc = (stk.pop_back() + 2) % 1024;
            end
            seq_core_pkg::OP_LOAD_IMM: begin
                acc = imm % 16;
                msk |= 'hf;
            end
            seq_core_pkg::OP_INC_ACC: begin
                cy = acc == 15;
                acc = (acc + 1) % 16;
                msk |= 'h10;
            end
            seq_core_pkg::OP_ROTATE_LEFT: begin
                cy = acc >> 3;
                acc = ((acc << 1) | ((ctl & 1) ? int'(serial_in_pin) : cy)) % 16;
            end
            seq_core_pkg::OP_SET_CARRY_IF_FULL: if (acc == 15) cy = 1;
            seq_core_pkg::OP_PIN_TEST: begin
                st = pin_match_pin;
                msk |= 'h20;
            end
            seq_core_pkg::OP_STORE_ACC: ram[ra] = acc;
            seq_core_pkg::OP_LOAD_ACC: acc = ram[ra];
            seq_core_pkg::OP_ADD_RAM: begin
                cy = (acc + ram[ra]) >> 4;
                acc = (acc + ram[ra]) % 16;
            end
            seq_core_pkg::OP_AND_RAM: acc = acc & ram[ra];
            seq_core_pkg::OP_OR_RAM: acc = acc | ram[ra];
            seq_core_pkg::OP_XOR_RAM: acc = acc ^ ram[ra];
            seq_core_pkg::OP_JUMP_INDIRECT: pc = imm & 'h3f0 | ram[ra] & 15;
            seq_core_pkg::OP_TABLE_READ: tab = (ctl >> 4 & 3) << 8 | (ram[16] & 15) << 4 | ram[0] & 15;
            default: ;
        endcase
        if (o == seq_core_pkg::OP_TABLE_READ) begin
            chk(table_addr, tab, 32'h3ff);
            chk(table_valid, 1, 1);
            @(negedge sys_clk);
            chk(table_valid, 0, 1);
            chk(table_word, rom_u.mem[tab], 32'h3ff);
        end
        chk_all();
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'hf7175b5b));
        repeat (3) @(posedge sys_clk);
        reset <= 0;
        chk_all();
        bus(0, 4'hc, 0);
        chk(reg_rdata, 0, 32'hffffffff);
        $display("test reset done");
        repeat (6) begin
            run(seq_core_pkg::OP_ADVANCE, 0, 0, $urandom_range(3, 1));
            run(seq_core_pkg::OP_JUMP_DIRECT, $urandom_range(1023, 0));
        end
        $display("test flow done");
        pin_match_pin <= 1;
        repeat (5) @(posedge sys_clk);
        run(seq_core_pkg::OP_PIN_TEST, 0);
        run(seq_core_pkg::OP_JUMP_ON_MATCH, 'h0f0);
        pin_match_pin <= 0;
        repeat (5) @(posedge sys_clk);
        run(seq_core_pkg::OP_PIN_TEST, 0);
        run(seq_core_pkg::OP_JUMP_ON_MATCH, 'h0ff, 0, 2);
        run(seq_core_pkg::OP_LOAD_IMM, 15);
        run(seq_core_pkg::OP_INC_ACC, 0);
        run(seq_core_pkg::OP_JUMP_ON_CARRY, 'h2aa);
        run(seq_core_pkg::OP_INC_ACC, 0);
        run(seq_core_pkg::OP_JUMP_ON_CARRY, 'h155);
        run(seq_core_pkg::OP_LOAD_IMM, 9);
        run(seq_core_pkg::OP_ROTATE_LEFT, 0);
        serial_in_pin <= 1;
        bus(1, 4'h0, 32'h1);
        ctl = 1;
        repeat (4) @(posedge sys_clk);
        run(seq_core_pkg::OP_ROTATE_LEFT, 0);
        run(seq_core_pkg::OP_LOAD_IMM, 14);
        run(seq_core_pkg::OP_SET_CARRY_IF_FULL, 0);
        run(seq_core_pkg::OP_LOAD_IMM, 15);
        run(seq_core_pkg::OP_SET_CARRY_IF_FULL, 0);
        $display("test flags done");
        for (int i = 0; i < 4; i++) run(seq_core_pkg::OP_CALL, 'h100 + i * 'h41);
        for (int i = 0; i < 4; i++) run(seq_core_pkg::OP_EXIT, 0);
        $display("test stack done");
        run(seq_core_pkg::OP_LOAD_IMM, 'ha);
        run(seq_core_pkg::OP_STORE_ACC, 0, 16);
        run(seq_core_pkg::OP_LOAD_IMM, 5);
        run(seq_core_pkg::OP_STORE_ACC, 0, 0);
        bus(1, 4'h0, 32'h20);
        ctl = 'h20;
        run(seq_core_pkg::OP_TABLE_READ, 0);
        $display("test table done");
        run(seq_core_pkg::OP_LOAD_ACC, 0, 16);
        run(seq_core_pkg::OP_ADD_RAM, 0, 16);
        run(seq_core_pkg::OP_AND_RAM, 0, 0);
        run(seq_core_pkg::OP_OR_RAM, 0, 16);
        run(seq_core_pkg::OP_XOR_RAM, 0, 0);
        run(seq_core_pkg::OP_JUMP_INDIRECT, 'h2c7, 16);
        $display("test alu done");
        run(seq_core_pkg::OP_CALL, 'h3c3);
        all_clear_pin <= 1;
        repeat (8) @(posedge sys_clk);
        all_clear_pin <= 0;
        repeat (8) @(posedge sys_clk);
        pc = 0;
        sp = 0;
        stk.delete();
        chk_all();
        bus(0, 4'h0, 0);
        chk(reg_rdata, 0, 32'h3ff);
        ctl = 0;
        run(seq_core_pkg::OP_TABLE_READ, 0);
        $display("test clear done");
        tally_and_finish();
    end
endmodule
